// ==== iood_core.sv ====
// execute unit for add, bit set and fill with indexed offset addressing
// Operation
// - extended mode, access bit clear, operand up to 5fh: offset from frame pointer
// - add opcode 0010 01d0 kkkk kkkk adds accumulator to indexed byte
// - destination bit clear sends sum to accumulator, set sends it to memory
// - add updates n, ov, c, dc, z; bit set and fill keep all flags
// - opcode 1000 bbb0 kkkk kkkk sets bit b of indexed byte only
// - opcode 0110 1000 kkkk kkkk writes ffh to indexed byte
// - fuse value zero keeps extended set and indexed addressing off
// - otherwise operand is literal address in access bank or selected bank
`timescale 1ns/1ps
module iood_core
	import iood_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	// configuration and pointers
	input  wire logic              extended_set_enable_fuse_i,
	input  wire logic [ADDR_W-1:0] stack_frame_pointer_i,
	input  wire logic [3:0]        bank_select_pointer_i,
	// instruction issue
	input  wire logic              instr_valid_i,
	input  wire logic [15:0]       instr_i,
	// data memory
	input  wire logic [DATA_W-1:0] mem_rdata_i,
	output logic [ADDR_W-1:0]      mem_addr_o,
	output logic                   mem_rd_o,
	output logic                   mem_wr_o,
	output logic [DATA_W-1:0]      mem_wdata_o,
	// architectural state
	output logic [DATA_W-1:0]      accum_o,
	output logic [4:0]             flags_o,
	output logic                   busy_o,
	output logic                   done_o
);
	typedef struct packed {
		iood_state_type    st;
		iood_dec_type      dec;
		logic              busy;
		logic [ADDR_W-1:0] addr;
		logic              rd;
		logic              wr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] accum;
		logic [4:0]        flags;
		logic              done;
	} iood_core_state_type;

	iood_core_state_type s_q, s_d;
	iood_dec_type        dec;
	logic [ADDR_W-1:0]   eff_addr;
	logic [DATA_W:0]     sum;
	logic [4:0]          lo_sum;
	logic [DATA_W-1:0]   res;
	logic                indexed;

	iood_decode u_decode (
		.instr_i (instr_i),
		.dec_o   (dec)
	);

	// address selection for the instruction being issued; the fuse is
	// looked at while idle, so the first instruction after reset sees it
	always_comb begin
		indexed = extended_set_enable_fuse_i && !dec.access_sel
			&& (dec.operand <= IDX_LIMIT);
		if (indexed) begin
			eff_addr = stack_frame_pointer_i
				+ {4'h0, dec.operand};
		end else if (dec.access_sel) begin
			eff_addr = {bank_select_pointer_i, dec.operand};
		end else if (dec.operand < ACCESS_SPLIT) begin
			eff_addr = {4'h0, dec.operand};
		end else begin
			eff_addr = {ACCESS_HI_BANK, dec.operand};
		end
	end

	// add datapath with half carry
	always_comb begin
		sum = {1'b0, s_q.accum} + {1'b0, mem_rdata_i};
		lo_sum = {1'b0, s_q.accum[3:0]} + {1'b0, mem_rdata_i[3:0]};
		res = sum[DATA_W-1:0];
	end

	// sequencer: read phase then write phase; fill goes straight to the write phase
	always_comb begin
		s_d = s_q;
		s_d.rd = 1'b0;
		s_d.wr = 1'b0;
		s_d.done = 1'b0;
		case (s_q.st)
			IOOD_IDLE: begin
				if (instr_valid_i && dec.op != IOOD_OP_NONE) begin
					s_d.dec = dec;
					s_d.addr = eff_addr;
					if (dec.op == IOOD_OP_FILL) begin
						s_d.wr = 1'b1;
						s_d.wdata = FILL_VAL;
						s_d.st = IOOD_WRITE;
					end else begin
						s_d.rd = 1'b1;
						s_d.st = IOOD_READ;
					end
				end
			end
			IOOD_READ: begin
				s_d.st = IOOD_WRITE;
				if (s_q.dec.op == IOOD_OP_ADD) begin
					s_d.flags[FLG_C] = sum[DATA_W];
					s_d.flags[FLG_DC] = lo_sum[4];
					s_d.flags[FLG_Z] = (res == ZERO8);
					s_d.flags[FLG_N] = res[DATA_W-1];
					s_d.flags[FLG_OV] = (s_q.accum[7] == mem_rdata_i[7])
						&& (res[7] != s_q.accum[7]);
					if (s_q.dec.dest_mem) begin
						s_d.wr = 1'b1;
						s_d.wdata = res;
					end else begin
						s_d.accum = res;
					end
				end else begin
					s_d.wr = 1'b1;
					s_d.wdata = mem_rdata_i
						| (8'h01 << s_q.dec.bit_sel);
				end
			end
			IOOD_WRITE: begin
				s_d.done = 1'b1;
				s_d.st = IOOD_IDLE;
			end
			default: s_d.st = IOOD_IDLE;
		endcase
		s_d.busy = (s_d.st != IOOD_IDLE); // registered busy output
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q <= '0;
			s_q.flags <= FLAGS_RST;
			s_q.addr <= ZERO12;
		end else begin
			s_q <= s_d;
		end
	end

	assign mem_addr_o = s_q.addr;
	assign mem_rd_o = s_q.rd;
	assign mem_wr_o = s_q.wr;
	assign mem_wdata_o = s_q.wdata;
	assign accum_o = s_q.accum;
	assign flags_o = s_q.flags;
	assign busy_o = s_q.busy;
	assign done_o = s_q.done;

	// indexed fill writes ffh at pointer plus offset next cycle
	a_fill_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_IDLE && instr_valid_i && dec.op == IOOD_OP_FILL
		&& indexed |=> mem_wr_o && mem_wdata_o == 8'hff
		&& mem_addr_o == $past(stack_frame_pointer_i)
		+ {4'h0, $past(instr_i[7:0])})
		else $error("indexed fill wrote wrong value or address");

	// fuse clear leaves low access-bank operands as literal addresses
	a_fuse_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_IDLE && instr_valid_i && dec.op != IOOD_OP_NONE
		&& !extended_set_enable_fuse_i && !dec.access_sel
		&& dec.operand < ACCESS_SPLIT
		|=> mem_addr_o == {4'h0, $past(instr_i[7:0])})
		else $error("indexed mode active with fuse clear");

	// flags unchanged by bit set
	a_flags_keep: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_READ && s_q.dec.op != IOOD_OP_ADD |=> $stable(flags_o))
		else $error("flags changed by bit set");

	// bit set preserves other bits
	a_bset_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_READ && s_q.dec.op == IOOD_OP_BSET
		|=> mem_wr_o && mem_wdata_o[$past(s_q.dec.bit_sel)]
		&& ((mem_wdata_o ^ $past(mem_rdata_i))
		& ~(8'h01 << $past(s_q.dec.bit_sel))) == 8'h00)
		else $error("bit set corrupted the byte");

	// add to accumulator does not write memory
	a_add_dest: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_READ && s_q.dec.op == IOOD_OP_ADD
		|=> mem_wr_o == $past(s_q.dec.dest_mem)
		&& (mem_wr_o ? mem_wdata_o : accum_o)
		== $past(s_q.accum) + $past(mem_rdata_i))
		else $error("add result went to wrong place");

	// add zero flag tracks sum
	a_add_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_READ && s_q.dec.op == IOOD_OP_ADD
		|=> flags_o[FLG_Z]
		== (8'($past(s_q.accum) + $past(mem_rdata_i)) == 8'h00)
		&& flags_o[FLG_C] == (({1'b0, $past(s_q.accum)}
		+ {1'b0, $past(mem_rdata_i)}) > 9'h0ff))
		else $error("add flags wrong");

	// literal addressing when access bit set
	a_bank_addr: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_IDLE && instr_valid_i && dec.op == IOOD_OP_ADD
		&& dec.access_sel |=> mem_addr_o
		== {$past(bank_select_pointer_i), $past(instr_i[7:0])})
		else $error("banked address wrong");

	// each add instruction completes in three cycles
	a_done_time: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_q.st == IOOD_IDLE && instr_valid_i && dec.op == IOOD_OP_ADD
		|=> busy_o ##1 busy_o ##1 done_o && !busy_o)
		else $error("add did not finish in time");
endmodule

// ==== iood_pkg.sv ====
// package for the indexed offset operand decoder
package iood_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam logic [7:0] IDX_LIMIT = 8'h5f; // highest indexed offset
	localparam logic [5:0] OP_ADD = 6'h09; // 0010 01
	localparam logic [3:0] OP_BSET = 4'h8; // 1000
	localparam logic [7:0] OP_FILL = 8'h68; // 0110 1000
	localparam logic [7:0] FILL_VAL = 8'hff;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [11:0] ZERO12 = 12'h000;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam int FLG_C = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N = 4;

	typedef enum logic [1:0] {
		IOOD_OP_NONE,
		IOOD_OP_ADD,
		IOOD_OP_BSET,
		IOOD_OP_FILL
	} iood_op_type;

	// decoded instruction fields
	typedef struct packed {
		iood_op_type op;
		logic        dest_mem;
		logic        access_sel;
		logic [2:0]  bit_sel;
		logic [7:0]  operand;
	} iood_dec_type;

	typedef enum logic [1:0] {
		IOOD_IDLE,
		IOOD_READ,
		IOOD_WRITE
	} iood_state_type;
endpackage

// ==== iood_decode.sv ====
// opcode field decoder for the indexed offset operations
`timescale 1ns/1ps
module iood_decode
	import iood_pkg::*;
(
	// instruction word
	input  wire logic [15:0] instr_i,
	// decoded fields
	output iood_dec_type     dec_o
);
	// pattern match on the high opcode byte
	always_comb begin
		dec_o.op = IOOD_OP_NONE;
		dec_o.dest_mem = instr_i[9];
		dec_o.access_sel = instr_i[8];
		dec_o.bit_sel = instr_i[11:9];
		dec_o.operand = instr_i[7:0];
		if (instr_i[15:10] == OP_ADD) begin
			dec_o.op = IOOD_OP_ADD;
		end else if (instr_i[15:12] == OP_BSET) begin
			dec_o.op = IOOD_OP_BSET;
		end else if (instr_i[15:8] == OP_FILL) begin
			dec_o.op = IOOD_OP_FILL;
			dec_o.access_sel = 1'b0;
		end
	end
endmodule

// ==== test_indexed_offset_operand_decode.sv ====
// self-checking bench for the indexed offset operand decoder
`timescale 1ns/1ps
module test_indexed_offset_operand_decode;
	import iood_pkg::*;
	logic        sys_clk_i = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic        fuse      = 1'b1;
	logic [11:0] fptr      = 12'ha00;
	logic [3:0]  bank      = 4'h3;
	logic        vld       = 1'b0;
	logic [15:0] ins       = 16'h0000;
	logic [7:0]  mem [4096];
	logic [11:0] addr;
	logic [11:0] wa;
	logic        rd;
	logic        wr;
	logic        busy;
	logic        done;
	logic [7:0]  wdata;
	logic [7:0]  acc;
	logic [4:0]  flg;
	int          err_count   = 0;
	int          checks_done = 0;
	int          cyc         = 0;

	// device under test
	iood_core iood_core_i (
		.sys_clk_i                 (sys_clk_i),
		.rst_b_i                   (rst_b_i),
		.extended_set_enable_fuse_i(fuse),
		.stack_frame_pointer_i     (fptr),
		.bank_select_pointer_i     (bank),
		.instr_valid_i             (vld),
		.instr_i                   (ins),
		.mem_rdata_i               (mem[addr]),
		.mem_addr_o                (addr),
		.mem_rd_o                  (rd),
		.mem_wr_o                  (wr),
		.mem_wdata_o               (wdata),
		.accum_o                   (acc),
		.flags_o                   (flg),
		.busy_o                    (busy),
		.done_o                    (done)
	);

	// clock, data memory writes and hang guard
	always #2 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (wr === 1'b1) begin
			mem[addr] <= wdata;
			wa        <= addr;
		end
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic compare(input string n, input logic [11:0] e,
		input logic [11:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	// issue one instruction and wait for completion
	task automatic run(input logic [15:0] i);
		int n;
		n = 0;
		vld <= 1'b1;
		ins <= i;
		@(posedge sys_clk_i);
		vld <= 1'b0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge sys_clk_i);
			n++;
		end
		compare("done", 12'h001, {11'h000, done});
		compare("busy", 12'h000, {11'h000, busy});
	endtask

	// add into accumulator and memory, all five flags
	task automatic t_add();
		mem[12'ha2c] = 8'h20;
		run(16'h242c);
		compare("acc", 12'h020, {4'h0, acc});
		compare("flags", 12'h000, {7'h00, flg});
		mem[12'ha2d] = 8'he0;
		run(16'h262d);
		compare("mem", 12'h000, {4'h0, mem[12'ha2d]});
		compare("addr", 12'ha2d, wa);
		compare("flags", 12'h005, {7'h00, flg});
		mem[12'ha2e] = 8'h68;
		run(16'h242e);
		compare("acc", 12'h088, {4'h0, acc});
		compare("flags", 12'h018, {7'h00, flg});
		mem[12'ha2f] = 8'h08;
		run(16'h262f);
		compare("mem", 12'h090, {4'h0, mem[12'ha2f]});
		compare("flags", 12'h012, {7'h00, flg});
	endtask

	// set bit 7 of an indexed byte, then each bit in its own indexed byte, flags kept
	task automatic t_bset();
		mem[12'ha0a] = 8'h55;
		run(16'h8e0a);
		compare("mem", 12'h0d5, {4'h0, mem[12'ha0a]});
		for (int b = 0; b < 8; b++) begin
			mem[12'ha40 + b] = 8'h00;
			run({4'h8, b[2:0], 1'b0, 8'h40 + b[7:0]});
			compare("bit", 12'h001 << b, {4'h0, mem[12'ha40 + b]});
		end
		compare("flags", 12'h012, {7'h00, flg});
	endtask

	// fill at top offset, then literal cases
	task automatic t_fill();
		mem[12'ha5f] = 8'h00;
		run(16'h685f);
		compare("mem", 12'h0ff, {4'h0, mem[12'ha5f]});
		compare("addr", 12'ha5f, wa);
		compare("flags", 12'h012, {7'h00, flg});
		run(16'h6860);
		compare("addr", 12'hf60, wa);
		mem[12'h32c] = 8'h00;
		run(16'h812c);
		compare("addr", 12'h32c, wa);
		compare("mem", 12'h001, {4'h0, mem[12'h32c]});
		fuse <= 1'b0;
		@(posedge sys_clk_i);
		run(16'h682c);
		compare("addr", 12'h02c, wa);
	endtask

	// reset, then the scenarios
	initial begin
		repeat (12) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		t_add();
		t_bset();
		t_fill();
		test_done();
	end
endmodule
